// ### pkg/lpm_pkg.sv
package lpm_pkg;

  // ----------------------------------------------------------------
  // Power states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_RUN,
    ST_SLEEP,
    ST_STOP,
    ST_STANDBY
  } pwr_state_t;

  // Target low-power mode requested by software
  localparam logic [1:0] TARGET_SLEEP = 2'h0;
  localparam logic [1:0] TARGET_STOP = 2'h1;
  localparam logic [1:0] TARGET_STANDBY = 2'h2;

  // Regulator mode encoding on the regulator port
  localparam logic [1:0] REG_MAIN = 2'h0;
  localparam logic [1:0] REG_LOW_POWER = 2'h1;
  localparam logic [1:0] REG_POWER_DOWN = 2'h2;

  // Trigger edge selection per event line
  localparam int EDGE_RISE_BIT = 0;
  localparam int EDGE_FALL_BIT = 1;

  // Event line layout: 16 pin lines, then supply detector, then alarm
  localparam int NUM_PIN_LINES = 16;
  localparam int LINE_SUPPLY = 16;
  localparam int LINE_ALARM = 17;
  localparam int NUM_LINES = 18;

  // Reset values
  localparam logic [NUM_LINES-1:0] LINES_RST = 18'h0_0000;
  localparam logic [1:0] REG_RST = 2'h0;

endpackage : lpm_pkg

// ### hw/low_power_mode_controller.sv
// Contract
// - Run uses main regulator mode
// - Stop default regulator is low-power mode
// - Standby powers regulator down, content lost
// - Regulator enabled after any reset
// - Sleep halts only the processor clock
// - Any interrupt or enabled event line leaves Sleep
// - Stop gates core clocks, PLL, oscillators
// - Stop regulator chosen by software select
// - Any enabled event line leaves Stop
// - Standby powers off core, PLL, oscillators
// - Reset pin, watchdog, wakeup, alarm exit Standby
// - RTC and watchdog clock keep running always
// - Per-line edge select and mask
`timescale 1ns/1ps
module low_power_mode_controller
  import lpm_pkg::*;
#(
  parameter int LINES = NUM_LINES
) (
  input wire logic clk_sys,
  input wire logic external_reset_pin,
  input wire logic sleep_request,
  input wire logic [1:0] target_mode,
  input wire logic stop_low_power_sel,
  input wire logic irq_pending,
  input wire logic [LINES-1:0] event_lines_in,
  input wire logic [LINES-1:0] event_mask,
  input wire logic [LINES-1:0] edge_rise_en,
  input wire logic [LINES-1:0] edge_fall_en,
  input wire logic external_reset_pin_n,
  input wire logic independent_watchdog_reset,
  input wire logic wakeup_pin,
  output logic cpu_clk_en,
  output logic periph_clk_en,
  output logic core_clk_en,
  output logic pll_en,
  output logic internal_fast_rc_oscillator_en,
  output logic external_fast_crystal_oscillator_en,
  output logic regulator_en,
  output logic [1:0] regulator_mode,
  output logic core_power_on,
  output logic retain_core_content,
  output logic rtc_watchdog_clk_en,
  output logic standby_exit_reset,
  output logic [1:0] state_out
);

  // ----------------------------------------------------------------
  // Event line edge detection
  // ----------------------------------------------------------------
  logic [LINES-1:0] line_prev_q; // Last sampled line levels
  logic [LINES-1:0] line_prev_d;
  logic [LINES-1:0] line_hit; // Unmasked edge seen this cycle
  logic wake_prev_q; // Last wakeup pin level
  logic wake_prev_d;

  // Per-line edge selection; generate keeps every line identical
  genvar gi;
  generate
    for (gi = 0; gi < LINES; gi++) begin : g_line
      always_comb begin
        line_hit[gi] = event_mask[gi] &
          ((edge_rise_en[gi] & event_lines_in[gi] & ~line_prev_q[gi]) |
           (edge_fall_en[gi] & ~event_lines_in[gi] & line_prev_q[gi]));
      end
    end
  endgenerate

  // Next level history
  always_comb begin
    line_prev_d = event_lines_in;
    wake_prev_d = wakeup_pin;
  end

  // History registers reset low so a line high at release reads as an edge
  always_ff @(posedge clk_sys or negedge external_reset_pin) begin
    if (!external_reset_pin) begin
      line_prev_q <= LINES_RST;
      wake_prev_q <= 1'b0;
    end else begin
      line_prev_q <= line_prev_d;
      wake_prev_q <= wake_prev_d;
    end
  end

  // ----------------------------------------------------------------
  // Wake and exit conditions
  // ----------------------------------------------------------------
  logic any_event; // Any unmasked event line edge
  logic standby_wake; // Any Standby exit source
  always_comb begin
    any_event = |line_hit;
    standby_wake = ~external_reset_pin_n | independent_watchdog_reset |
                   (wakeup_pin & ~wake_prev_q) | event_lines_in[LINE_ALARM];
  end

  // ----------------------------------------------------------------
  // Power state machine
  // ----------------------------------------------------------------
  pwr_state_t state_q; // Current power state
  pwr_state_t state_d;
  logic stop_lp_q; // Latched Stop regulator choice
  logic stop_lp_d;
  logic exit_rst_d;

  // Target and regulator select are sampled only on the request
  always_comb begin
    state_d = state_q;
    stop_lp_d = stop_lp_q;
    exit_rst_d = 1'b0;
    case (state_q)
      ST_RUN: begin
        if (sleep_request) begin
          case (target_mode)
            TARGET_SLEEP: state_d = ST_SLEEP;
            TARGET_STOP: begin
              state_d = ST_STOP;
              stop_lp_d = stop_low_power_sel;
            end
            TARGET_STANDBY: state_d = ST_STANDBY;
            default: state_d = ST_RUN; // Unknown target: stay running
          endcase
        end
      end
      ST_SLEEP: begin
        if (irq_pending || any_event) begin
          state_d = ST_RUN;
        end
      end
      ST_STOP: begin
        if (any_event) begin
          state_d = ST_RUN;
        end
      end
      ST_STANDBY: begin
        // Exit is a full reset of the core since its content is gone
        if (standby_wake) begin
          state_d = ST_RUN;
          exit_rst_d = 1'b1;
        end
      end
      default: state_d = ST_RUN;
    endcase
  end

  always_ff @(posedge clk_sys or negedge external_reset_pin) begin
    if (!external_reset_pin) begin
      state_q <= ST_RUN;
      stop_lp_q <= 1'b1;
      standby_exit_reset <= 1'b0;
    end else begin
      state_q <= state_d;
      stop_lp_q <= stop_lp_d;
      standby_exit_reset <= exit_rst_d;
    end
  end

  // ----------------------------------------------------------------
  // Output decode, registered from next state
  // ----------------------------------------------------------------
  logic cpu_d, per_d, core_d, osc_d, reg_en_d, pwr_d, ret_d;
  logic [1:0] reg_mode_d;

  // Outputs follow state_d so they align with state_q on each edge
  always_comb begin
    cpu_d = 1'b1;
    per_d = 1'b1;
    core_d = 1'b1;
    osc_d = 1'b1;
    reg_en_d = 1'b1;
    pwr_d = 1'b1;
    ret_d = 1'b1;
    reg_mode_d = REG_MAIN;
    case (state_d)
      ST_RUN: reg_mode_d = REG_MAIN;
      ST_SLEEP: cpu_d = 1'b0;
      ST_STOP: begin
        cpu_d = 1'b0;
        per_d = 1'b0;
        core_d = 1'b0;
        osc_d = 1'b0;
        reg_mode_d = stop_lp_d ? REG_LOW_POWER : REG_MAIN;
      end
      ST_STANDBY: begin
        cpu_d = 1'b0;
        per_d = 1'b0;
        core_d = 1'b0;
        osc_d = 1'b0;
        reg_en_d = 1'b0;
        pwr_d = 1'b0;
        ret_d = 1'b0;
        reg_mode_d = REG_POWER_DOWN;
      end
      default: reg_mode_d = REG_MAIN;
    endcase
  end

  always_ff @(posedge clk_sys or negedge external_reset_pin) begin
    if (!external_reset_pin) begin
      cpu_clk_en <= 1'b1;
      periph_clk_en <= 1'b1;
      core_clk_en <= 1'b1;
      pll_en <= 1'b1;
      internal_fast_rc_oscillator_en <= 1'b1;
      external_fast_crystal_oscillator_en <= 1'b1;
      regulator_en <= 1'b1;
      regulator_mode <= REG_RST;
      core_power_on <= 1'b1;
      retain_core_content <= 1'b1;
      rtc_watchdog_clk_en <= 1'b1;
      state_out <= 2'h0;
    end else begin
      cpu_clk_en <= cpu_d;
      periph_clk_en <= per_d;
      core_clk_en <= core_d;
      pll_en <= osc_d;
      internal_fast_rc_oscillator_en <= osc_d;
      external_fast_crystal_oscillator_en <= osc_d;
      regulator_en <= reg_en_d;
      regulator_mode <= reg_mode_d;
      core_power_on <= pwr_d;
      retain_core_content <= ret_d;
      rtc_watchdog_clk_en <= 1'b1;
      state_out <= state_d;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_run_main_reg: assert property (@(posedge clk_sys) disable iff (!external_reset_pin)
    state_q == ST_RUN |-> regulator_mode == REG_MAIN)
    else $error("Run without main regulator");
  a_stop_reg_sel: assert property (@(posedge clk_sys) disable iff (!external_reset_pin)
    state_q == ST_STOP |-> regulator_mode == (stop_lp_q ? REG_LOW_POWER : REG_MAIN))
    else $error("Stop regulator does not follow select");
  a_standby_off: assert property (@(posedge clk_sys) disable iff (!external_reset_pin)
    state_q == ST_STANDBY |-> !regulator_en && !core_power_on && !retain_core_content)
    else $error("Standby still powered");
  a_sleep_clocks: assert property (@(posedge clk_sys) disable iff (!external_reset_pin)
    state_q == ST_SLEEP |-> !cpu_clk_en && periph_clk_en && core_clk_en)
    else $error("Sleep clock gating wrong");
  a_sleep_wake: assert property (@(posedge clk_sys) disable iff (!external_reset_pin)
    state_q == ST_SLEEP && irq_pending |=> state_q == ST_RUN && cpu_clk_en)
    else $error("Sleep did not wake");
  a_stop_gating: assert property (@(posedge clk_sys) disable iff (!external_reset_pin)
    state_q == ST_STOP |-> !core_clk_en && !pll_en && !internal_fast_rc_oscillator_en
      && !external_fast_crystal_oscillator_en && retain_core_content)
    else $error("Stop gating wrong");
  a_stop_wake: assert property (@(posedge clk_sys) disable iff (!external_reset_pin)
    state_q == ST_STOP && any_event |=> state_q == ST_RUN)
    else $error("Stop did not wake on event");
  a_standby_exit: assert property (@(posedge clk_sys) disable iff (!external_reset_pin)
    state_q == ST_STANDBY && !external_reset_pin_n |=> state_q == ST_RUN && standby_exit_reset)
    else $error("Standby did not exit");
  a_rtc_clock: assert property (@(posedge clk_sys) disable iff (!external_reset_pin)
    $fell(cpu_clk_en) |-> rtc_watchdog_clk_en)
    else $error("Always-on clock stopped");
  // No unmasked edge of a selected kind means Stop must hold
  a_mask_line: assert property (@(posedge clk_sys) disable iff (!external_reset_pin)
    state_q == ST_STOP && ((event_mask & ((edge_rise_en & event_lines_in & ~line_prev_q) |
      (edge_fall_en & ~event_lines_in & line_prev_q))) == '0) |=> state_q == ST_STOP)
    else $error("Masked lines woke Stop");

endmodule : low_power_mode_controller

// ### testbench/core_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Processor core: issues the low-power request
// ----------------------------------------------------------------
module core_model
  import lpm_pkg::*;
(
  input wire logic clk_sys,
  input wire logic external_reset_pin,
  input wire logic go,
  input wire logic [1:0] tgt,
  input wire logic [1:0] state_out,
  output logic sleep_request,
  output logic [1:0] target_mode
);
  // Target leads the request by an edge, so the mode is settled when taken.
  // The request drops once the block has left Run, since it is ignored there.
  always @(posedge clk_sys or negedge external_reset_pin) begin
    if (!external_reset_pin) begin
      sleep_request <= 1'b0;
      target_mode <= TARGET_SLEEP;
    end else begin
      target_mode <= tgt;
      sleep_request <= go && (target_mode == tgt) && (state_out == ST_RUN);
    end
  end
endmodule : core_model

// ### testbench/low_power_mode_controller_bench.sv
`timescale 1ns/1ps
module low_power_mode_controller_bench;
  import lpm_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic clk_sys, external_reset_pin, go, stop_low_power_sel, irq_pending, external_reset_pin_n;
  logic independent_watchdog_reset, wakeup_pin, sleep_request;
  logic [1:0] tgt, target_mode, regulator_mode, state_out;
  logic [NUM_LINES-1:0] event_lines_in, event_mask, edge_rise_en, edge_fall_en;
  logic cpu_clk_en, periph_clk_en, core_clk_en, pll_en, regulator_en, core_power_on;
  logic internal_fast_rc_oscillator_en, external_fast_crystal_oscillator_en;
  logic retain_core_content, rtc_watchdog_clk_en, standby_exit_reset;
  logic [14:0] obs, prev; // Packed outputs, now and last cycle
  logic [14:0] notes[$]; // Expected outputs, oldest first
  logic [31:0] rng; // Xorshift state
  int errors, check_count, k;
  assign obs = {standby_exit_reset, cpu_clk_en, periph_clk_en, core_clk_en, pll_en,
    internal_fast_rc_oscillator_en, external_fast_crystal_oscillator_en, regulator_en,
    regulator_mode, core_power_on, retain_core_content, rtc_watchdog_clk_en, state_out};
  low_power_mode_controller dut (
    .clk_sys(clk_sys),
    .external_reset_pin(external_reset_pin),
    .sleep_request(sleep_request),
    .target_mode(target_mode),
    .stop_low_power_sel(stop_low_power_sel),
    .irq_pending(irq_pending),
    .event_lines_in(event_lines_in),
    .event_mask(event_mask),
    .edge_rise_en(edge_rise_en),
    .edge_fall_en(edge_fall_en),
    .external_reset_pin_n(external_reset_pin_n),
    .independent_watchdog_reset(independent_watchdog_reset),
    .wakeup_pin(wakeup_pin),
    .cpu_clk_en(cpu_clk_en),
    .periph_clk_en(periph_clk_en),
    .core_clk_en(core_clk_en),
    .pll_en(pll_en),
    .internal_fast_rc_oscillator_en(internal_fast_rc_oscillator_en),
    .external_fast_crystal_oscillator_en(external_fast_crystal_oscillator_en),
    .regulator_en(regulator_en),
    .regulator_mode(regulator_mode),
    .core_power_on(core_power_on),
    .retain_core_content(retain_core_content),
    .rtc_watchdog_clk_en(rtc_watchdog_clk_en),
    .standby_exit_reset(standby_exit_reset),
    .state_out(state_out)
  );
  core_model core (
    .clk_sys(clk_sys),
    .external_reset_pin(external_reset_pin),
    .go(go),
    .tgt(tgt),
    .state_out(state_out),
    .sleep_request(sleep_request),
    .target_mode(target_mode)
  );
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  function automatic logic [31:0] xs();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction : xs
  // Expected output set per state; the watchdog clock never stops
  function automatic logic [14:0] ev(input logic [1:0] s, input logic sel, input logic x);
    case (s)
      ST_RUN: return {x, 7'h7f, REG_MAIN, 3'h7, s};
      ST_SLEEP: return {1'b0, 7'h3f, REG_MAIN, 3'h7, s};
      ST_STOP: return {1'b0, 7'h01, sel ? REG_LOW_POWER : REG_MAIN, 3'h7, s};
      default: return {1'b0, 7'h00, REG_POWER_DOWN, 3'h1, s};
    endcase
  endfunction : ev
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clk_sys);
      #1;
    end
  endtask : tick
  // Ask the core for a low-power mode; code 3 must leave the state alone
  task automatic enter(input logic [1:0] t, input logic [1:0] s);
    tgt = t;
    go = 1'b1;
    if (t != 2'h3) notes.push_back(ev(s, stop_low_power_sel, 1'b0));
    tick(4);
    go = 1'b0;
    tick(2);
  endtask : enter
  task automatic report_and_stop();
    $display("errors=%0d checks=%0d pending=%0d", errors, check_count, notes.size());
    if (errors == 0 && check_count > 0 && notes.size() == 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : report_and_stop
  // ----------------------------------------------------------------
  // Monitor: every state change must match the oldest note
  // ----------------------------------------------------------------
  always @(posedge clk_sys) begin
    #2;
    if (obs[1:0] !== prev[1:0]) begin
      check_count++;
      if (notes.size() == 0) begin
        errors++;
        $display("ERROR %0t unexpected state change", $time);
      end else begin
        if (obs !== notes[0]) begin
          errors++;
          $display("ERROR %0t outputs %h expected %h", $time, obs, notes[0]);
        end
        void'(notes.pop_front());
      end
    end
    prev = obs;
  end
  // Hang guard, far beyond the roughly 115 cycles of the sequence
  initial begin
    #500_000;
    errors++;
    report_and_stop();
  end
  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    rng = 32'h0000_0052;
    {external_reset_pin, go, tgt, irq_pending, independent_watchdog_reset, wakeup_pin} = '0;
    {stop_low_power_sel, external_reset_pin_n} = 2'h3;
    {event_lines_in, event_mask, edge_rise_en, edge_fall_en} = '0;
    errors = 0;
    check_count = 0;
    prev = ev(ST_RUN, 1'b0, 1'b0);
    repeat (6) @(posedge clk_sys);
    #1 external_reset_pin = 1'b1;
    tick(2);
    // Sleep woken by an interrupt level, then by an enabled rising edge
    enter(TARGET_SLEEP, ST_SLEEP);
    notes.push_back(ev(ST_RUN, 1'b0, 1'b0));
    irq_pending = 1'b1;
    tick(3);
    irq_pending = 1'b0;
    k = int'(xs() % NUM_PIN_LINES);
    event_mask[k] = 1'b1;
    edge_rise_en[k] = 1'b1;
    enter(TARGET_SLEEP, ST_SLEEP);
    notes.push_back(ev(ST_RUN, 1'b0, 1'b0));
    event_lines_in[k] = 1'b1;
    tick(3);
    // Stop with both regulator selections; only the falling edge of line k wakes
    for (int s = 0; s < 2; s++) begin
      stop_low_power_sel = s[0];
      k = int'(xs() % NUM_LINES);
      {event_lines_in, event_mask, edge_fall_en} = '0;
      // Every other line may rise but is masked; line k counts only on its fall
      edge_rise_en = '1;
      edge_rise_en[k] = 1'b0;
      event_mask[k] = 1'b1;
      edge_fall_en[k] = 1'b1;
      enter(TARGET_STOP, ST_STOP);
      stop_low_power_sel = ~s[0];
      event_lines_in = '1;
      irq_pending = 1'b1;
      tick(5);
      irq_pending = 1'b0;
      notes.push_back(ev(ST_RUN, 1'b0, 1'b0));
      event_lines_in[k] = 1'b0;
      tick(3);
    end
    // Standby left by each of its four exit sources
    {event_lines_in, event_mask} = '0;
    for (int s = 0; s < 4; s++) begin
      enter(TARGET_STANDBY, ST_STANDBY);
      notes.push_back(ev(ST_RUN, 1'b0, 1'b1));
      case (s)
        0: external_reset_pin_n = 1'b0;
        1: independent_watchdog_reset = 1'b1;
        2: wakeup_pin = 1'b1;
        default: event_lines_in[LINE_ALARM] = 1'b1;
      endcase
      tick(1);
      {independent_watchdog_reset, wakeup_pin, event_lines_in} = '0;
      external_reset_pin_n = 1'b1;
      tick(3);
    end
    // Undefined target code is refused, then a reset cuts Stop short
    enter(2'h3, ST_RUN);
    enter(TARGET_STOP, ST_STOP);
    notes.push_back(ev(ST_RUN, 1'b0, 1'b0));
    external_reset_pin = 1'b0;
    tick(6);
    external_reset_pin = 1'b1;
    tick(3);
    report_and_stop();
  end
endmodule : low_power_mode_controller_bench
